// >>> hdl/pac_pkg.sv
// package for the power control and alarm status register bank
// assumes 16-bit register addresses and 8-bit register data
package pac_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    // power control block
    localparam logic [15:0] ADDR_PWR_PATH = 16'h00A0;
    localparam logic [15:0] ADDR_PWR_AUX = 16'h00A1;
    localparam logic [15:0] ADDR_PWR_FB = 16'h00A2;

    // interrupt status block
    localparam logic [15:0] ADDR_STAT0 = 16'h0200;
    localparam logic [15:0] ADDR_STAT1 = 16'h0201;
    localparam logic [15:0] ADDR_STAT2 = 16'h0202;
    localparam logic [15:0] ADDR_STAT3 = 16'h0203;

    // field positions in the path byte
    localparam int BIT_PATH_A = 0;
    localparam int BIT_PATH_B = 1;
    localparam int BIT_PATH_C = 2;
    localparam int BIT_PATH_D = 3;

    // field positions in the auxiliary byte
    localparam int BIT_PATH_I = 0;
    localparam int BIT_PATH_J = 1;
    localparam int BIT_REF = 4;

    // field position in the feedback byte
    localparam int BIT_FB_INT = 1;

    // field positions in status byte one
    localparam int BIT_LOCK_LOSS = 0;
    localparam int BIT_SIGNAL_LOSS = 1;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic RST_BIT = 1'b0;

    // stages of the alarm input synchroniser
    localparam int SYNC_STAGES = 3;

    typedef struct packed {
        logic pathAPowerdown;
        logic pathBPowerdown;
        logic pathCPowerdown;
        logic pathDPowerdown;
        logic pathIPowerdown;
        logic pathJPowerdown;
        logic refPowerdown;
        logic feedbackIntegerSelect;
    } pac_power_t;

    typedef struct packed {
        logic lockLoss;
        logic signalLoss;
    } pac_alarm_t;

endpackage

// >>> hdl/pac_power_alarm_regs.sv
// power-down controls and sticky alarm status behind the serial port
// assumes a serial port engine issuing byte reads and writes, one per
// strobe, and alarm levels arriving from outside the clock domain
//
// Behaviour
// - reference output bit one powers its buffer down, zero runs it
// - path bit one powers divider, buffers and mux down, zero enables
// - feedback bit zero selects fractional mode, one integer mode
// - alarm condition sets its matching status bit
// - status bit stays set until a one is written to it
// - alarm pins follow the live alarm, never latched
// - lock loss bit in byte 0201 reads one after any lock loss seen on two successive ref_clk samples
// - signal loss bit reads one after any input signal loss seen on two successive ref_clk samples
`timescale 1ns/10ps
module pac_power_alarm_regs (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [15:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    output logic regRdValid,
    input wire pac_pkg::pac_alarm_t alarmIn,
    output pac_pkg::pac_power_t powerCtrl,
    output pac_pkg::pac_alarm_t alarmPin,
    output pac_pkg::pac_alarm_t alarmSticky
);
    import pac_pkg::*;

    // sticky next value: set has priority over write-one clear
    function automatic logic stickyNext(
        input logic cur,
        input logic setEv,
        input logic clrEv
    );
        logic res;
        res = setEv | (cur & ~clrEv);
        return res;
    endfunction

    // address decode
    logic selPath;
    logic selAux;
    logic selFb;
    logic selStat0;
    logic selStat1;
    logic selStat2;
    logic selStat3;

    assign selPath = (regAddr == ADDR_PWR_PATH);
    assign selAux = (regAddr == ADDR_PWR_AUX);
    assign selFb = (regAddr == ADDR_PWR_FB);
    assign selStat0 = (regAddr == ADDR_STAT0);
    assign selStat1 = (regAddr == ADDR_STAT1);
    assign selStat2 = (regAddr == ADDR_STAT2);
    assign selStat3 = (regAddr == ADDR_STAT3);

    // write strobes
    logic wrPath;
    logic wrAux;
    logic wrFb;
    logic wrStat1;

    assign wrPath = regWrEn & selPath;
    assign wrAux = regWrEn & selAux;
    assign wrFb = regWrEn & selFb;
    assign wrStat1 = regWrEn & selStat1;

    // power control storage
    pac_power_t power_q;
    pac_power_t power_d;

    always_comb begin
        power_d = power_q;
        if (wrPath) begin
            power_d.pathAPowerdown = regWrData[BIT_PATH_A];
            power_d.pathBPowerdown = regWrData[BIT_PATH_B];
            power_d.pathCPowerdown = regWrData[BIT_PATH_C];
            power_d.pathDPowerdown = regWrData[BIT_PATH_D];
        end
        if (wrAux) begin
            power_d.pathIPowerdown = regWrData[BIT_PATH_I];
            power_d.pathJPowerdown = regWrData[BIT_PATH_J];
            power_d.refPowerdown = regWrData[BIT_REF];
        end
        if (wrFb) begin
            power_d.feedbackIntegerSelect = regWrData[BIT_FB_INT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            power_q <= '0;
        end else begin
            power_q <= power_d;
        end
    end

    assign powerCtrl = power_q;

    // alarm synchroniser and filter
    logic [1:0] alarmLevel;
    pac_alarm_t alarmLive;

    pac_sync_filter #(
        .WIDTH(2)
    ) alarmSync (
        .ref_clk(ref_clk),
        .rst(rst),
        .asyncIn({alarmIn.lockLoss, alarmIn.signalLoss}),
        .levelOut(alarmLevel)
    );

    assign alarmLive.lockLoss = alarmLevel[1];
    assign alarmLive.signalLoss = alarmLevel[0];

    // live alarm pins
    pac_alarm_t pin_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_q <= '0;
        end else begin
            pin_q <= alarmLive;
        end
    end

    assign alarmPin = pin_q;

    // sticky status bits
    logic clrLock;
    logic clrSignal;
    pac_alarm_t sticky_q;
    pac_alarm_t sticky_d;

    assign clrLock = wrStat1 & regWrData[BIT_LOCK_LOSS];
    assign clrSignal = wrStat1 & regWrData[BIT_SIGNAL_LOSS];

    always_comb begin
        sticky_d.lockLoss = stickyNext(sticky_q.lockLoss,
            alarmLive.lockLoss, clrLock);
        sticky_d.signalLoss = stickyNext(sticky_q.signalLoss,
            alarmLive.signalLoss, clrSignal);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sticky_q <= '0;
        end else begin
            sticky_q <= sticky_d;
        end
    end

    assign alarmSticky = sticky_q;

    // read data assembly, reserved bits zero
    logic [7:0] rdPath;
    logic [7:0] rdAux;
    logic [7:0] rdFb;
    logic [7:0] rdStat1;
    logic [7:0] rdMux;

    always_comb begin
        rdPath = RST_BYTE;
        rdPath[BIT_PATH_A] = power_q.pathAPowerdown;
        rdPath[BIT_PATH_B] = power_q.pathBPowerdown;
        rdPath[BIT_PATH_C] = power_q.pathCPowerdown;
        rdPath[BIT_PATH_D] = power_q.pathDPowerdown;
    end

    always_comb begin
        rdAux = RST_BYTE;
        rdAux[BIT_PATH_I] = power_q.pathIPowerdown;
        rdAux[BIT_PATH_J] = power_q.pathJPowerdown;
        rdAux[BIT_REF] = power_q.refPowerdown;
    end

    always_comb begin
        rdFb = RST_BYTE;
        rdFb[BIT_FB_INT] = power_q.feedbackIntegerSelect;
    end

    always_comb begin
        rdStat1 = RST_BYTE;
        rdStat1[BIT_LOCK_LOSS] = sticky_q.lockLoss;
        rdStat1[BIT_SIGNAL_LOSS] = sticky_q.signalLoss;
    end

    always_comb begin
        if (selPath) begin
            rdMux = rdPath;
        end else if (selAux) begin
            rdMux = rdAux;
        end else if (selFb) begin
            rdMux = rdFb;
        end else if (selStat1) begin
            rdMux = rdStat1;
        end else if (selStat0 | selStat2 | selStat3) begin
            rdMux = RST_BYTE;
        end else begin
            rdMux = RST_BYTE;
        end
    end

    // read answer one cycle after the strobe
    logic [7:0] rdData_q;
    logic rdValid_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdData_q <= RST_BYTE;
            rdValid_q <= RST_BIT;
        end else begin
            rdValid_q <= regRdEn;
            if (regRdEn) begin
                rdData_q <= rdMux;
            end
        end
    end

    assign regRdData = rdData_q;
    assign regRdValid = rdValid_q;

endmodule

// >>> hdl/pac_sync_filter.sv
// three-stage synchroniser with agreement filter for alarm levels
// assumes inputs asynchronous to ref_clk; output changes on agreement
`timescale 1ns/10ps
module pac_sync_filter #(
    parameter int WIDTH = 2
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] levelOut
);
    import pac_pkg::*;

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;
    logic [WIDTH-1:0] stage3_q;
    logic [WIDTH-1:0] level_q;
    logic [WIDTH-1:0] level_d;
    logic [WIDTH-1:0] agree;

    assign agree = ~(stage2_q ^ stage3_q);
    assign level_d = (agree & stage3_q) | (~agree & level_q);
    assign levelOut = level_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stage1_q <= '0;
            stage2_q <= '0;
            stage3_q <= '0;
            level_q <= '0;
        end else begin
            stage1_q <= asyncIn;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
            level_q <= level_d;
        end
    end

endmodule

// >>> testbench/pac_regs_monitor.sv
// assertions on the power and alarm register bank ports
// assumes bind onto pac_power_alarm_regs
`timescale 1ns/10ps
module pac_regs_monitor (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [15:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid,
    input wire pac_pkg::pac_alarm_t alarmIn,
    input wire pac_pkg::pac_power_t powerCtrl,
    input wire pac_pkg::pac_alarm_t alarmPin,
    input wire pac_pkg::pac_alarm_t alarmSticky
);
    import pac_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire logic wrPath = regWrEn && regAddr == ADDR_PWR_PATH;
    wire logic wrAux = regWrEn && regAddr == ADDR_PWR_AUX;
    wire logic wrFb = regWrEn && regAddr == ADDR_PWR_FB;
    wire logic clrLock = regWrEn && regAddr == ADDR_STAT1 && regWrData[0];
    wire logic rdStat = regRdEn && regAddr == ADDR_STAT1;
    a_path_write: assert property (wrPath |=> {
        powerCtrl.pathDPowerdown, powerCtrl.pathCPowerdown,
        powerCtrl.pathBPowerdown, powerCtrl.pathAPowerdown}
        == $past(regWrData[3:0])) else $error("path bits wrong");
    a_aux_write: assert property (wrAux |=> {
        powerCtrl.refPowerdown, powerCtrl.pathJPowerdown,
        powerCtrl.pathIPowerdown} == $past({regWrData[4], regWrData[1:0]}))
        else $error("aux bits wrong");
    a_fb_write: assert property (wrFb |=>
        powerCtrl.feedbackIntegerSelect == $past(regWrData[1]))
        else $error("feedback select wrong");
    a_lock_set: assert property (
        alarmPin.lockLoss |-> alarmSticky.lockLoss)
        else $error("lock sticky not set");
    a_signal_set: assert property (
        alarmPin.signalLoss |-> alarmSticky.signalLoss)
        else $error("signal sticky not set");
    a_lock_hold: assert property (
        alarmSticky.lockLoss && !clrLock |=> alarmSticky.lockLoss)
        else $error("lock sticky lost");
    a_lock_clear: assert property (
        clrLock && !alarmPin.lockLoss |=>
        alarmSticky.lockLoss == alarmPin.lockLoss)
        else $error("lock sticky clear wrong");
    a_pin_follow: assert property (
        alarmIn.lockLoss [*8] |-> alarmPin.lockLoss)
        else $error("lock pin not following");
    a_pin_release: assert property (
        !alarmIn.signalLoss [*8] |-> !alarmPin.signalLoss)
        else $error("signal pin latched");
    a_status_read: assert property (rdStat |=> regRdValid &&
        regRdData[1:0] == $past({alarmSticky.signalLoss,
        alarmSticky.lockLoss})) else $error("status read wrong");
endmodule

// >>> testbench/tb_top.sv
// self-checking bench for the power and alarm register bank
// assumes design files and monitor compiled before it
`timescale 1ns/10ps
module tb_top;
    import pac_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] regAddr = 16'h0000;
    logic regWrEn = 1'b0;
    logic [7:0] regWrData = 8'h00;
    logic regRdEn = 1'b0;
    logic [7:0] regRdData;
    logic regRdValid;
    pac_alarm_t alarmIn = '0;
    pac_power_t powerCtrl;
    pac_alarm_t alarmPin;
    pac_alarm_t alarmSticky;
    int errorCnt = 0;
    int compares = 0;
    int cycles = 0;
    wire logic [7:0] pinB = {6'h00, alarmPin.signalLoss, alarmPin.lockLoss};
    wire logic [7:0] stkB = {6'h00, alarmSticky.signalLoss,
        alarmSticky.lockLoss};
    pac_power_alarm_regs u_dut (.ref_clk, .rst, .regAddr, .regWrEn,
        .regWrData, .regRdEn, .regRdData, .regRdValid, .alarmIn,
        .powerCtrl, .alarmPin, .alarmSticky);
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errorCnt++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", compares, errorCnt);
        if (errorCnt == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        compares++;
        if (got !== exp) begin
            errorCnt++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic step(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(logic [15:0] a, logic [7:0] d);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        step(1);
        regWrEn = 1'b0;
        step(1);
    endtask
    task automatic rd(logic [15:0] a, logic [7:0] exp, string what);
        regAddr = a;
        regRdEn = 1'b1;
        step(1);
        regRdEn = 1'b0;
        chk("read valid", 8'h01, {7'h00, regRdValid});
        chk(what, exp, regRdData);
        step(1);
    endtask
    task automatic t_defaults();
        logic [15:0] ads [8] = '{ADDR_PWR_PATH, ADDR_PWR_AUX, ADDR_PWR_FB,
            ADDR_STAT0, ADDR_STAT1, ADDR_STAT2, ADDR_STAT3, 16'h0300};
        foreach (ads[i]) rd(ads[i], 8'h00, "reset value");
        chk("power reset", 8'h00, powerCtrl);
        $display("test defaults done");
    endtask
    task automatic t_power();
        wr(ADDR_PWR_PATH, 8'h0F);
        wr(ADDR_PWR_AUX, 8'h13);
        wr(ADDR_PWR_FB, 8'h02);
        chk("power all down", 8'hFF, powerCtrl);
        rd(ADDR_PWR_AUX, 8'h13, "aux readback");
        wr(ADDR_PWR_PATH, 8'h05);
        wr(ADDR_PWR_AUX, 8'h00);
        wr(ADDR_PWR_FB, 8'h00);
        chk("power mixed", 8'hA0, powerCtrl);
        rd(ADDR_PWR_PATH, 8'h05, "path readback");
        $display("test power done");
    endtask
    task automatic t_alarm(int i);
        logic [7:0] m;
        m = 8'h01 << i;
        alarmIn = {m[0], m[1]};
        step(6);
        chk("pin raised", m, pinB);
        chk("sticky set", m, stkB);
        alarmIn = '0;
        step(6);
        chk("pin dropped", 8'h00, pinB);
        chk("sticky held", m, stkB);
        wr(ADDR_STAT1, 8'h00);
        chk("sticky zero write", m, stkB);
        rd(ADDR_STAT1, m, "status read");
        wr(ADDR_STAT1, m);
        chk("sticky cleared", 8'h00, stkB);
        $display("test alarm %0d done", i);
    endtask
    task automatic t_clash();
        alarmIn = 2'b11;
        step(6);
        wr(ADDR_STAT1, 8'h03);
        chk("set beats clear", 8'h03, stkB);
        alarmIn = '0;
        step(6);
        wr(ADDR_STAT1, 8'h03);
        chk("both cleared", 8'h00, stkB);
        $display("test clash done");
    endtask
    task automatic t_reset();
        wr(ADDR_PWR_AUX, 8'h13);
        alarmIn = 2'b11;
        step(6);
        rst = 1'b1;
        alarmIn = '0;
        step(4);
        rst = 1'b0;
        step(1);
        chk("power after reset", 8'h00, powerCtrl);
        chk("pin after reset", 8'h00, pinB);
        chk("sticky after reset", 8'h00, stkB);
        rd(ADDR_STAT1, 8'h00, "status after reset");
        $display("test reset done");
    endtask
    initial begin
        step(10);
        rst = 1'b0;
        step(4);
        t_defaults();
        t_power();
        t_alarm(0);
        t_alarm(1);
        t_clash();
        t_reset();
        close_out();
    end
endmodule
bind pac_power_alarm_regs pac_regs_monitor u_mon (.ref_clk, .rst,
    .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData, .regRdValid,
    .alarmIn, .powerCtrl, .alarmPin, .alarmSticky);
